//--- logic/sfrsd_space.sv
// Purpose: Special function register space decoder and core registers
// Assumes: One request per cycle, answered on the next edge
// Notes:   Straps and reset kind set reset values during synchronous reset; the variant strap also selects the device code at all times

`timescale 1ns/1ps
`default_nettype none

module sfrsd_space #(
    // Arbitrary neutral identification values
    parameter logic [7:0] CODE_LARGE = 8'h3a,
    parameter logic [7:0] CODE_SMALL = 8'h39
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  nrst_i,
    input  wire logic                  por_i,
    // Straps
    input  wire logic                  variant_small_i,
    input  wire logic                  boot_ctx_i,
    // Core access
    input  wire sfrsd_pkg::sfrsd_req_s req_i,
    output logic                       ack_o,
    output logic [7:0]                 rdata_o,
    output logic                       rbit_o,
    // Flash status from outside
    input  wire logic [7:0]            flash_status_i,
    // Register contents
    output sfrsd_pkg::sfrsd_regs_s     regs_o,
    output logic                       unlocked_o
);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [7:0] sfr_read(
        input sfrsd_pkg::sfrsd_regs_s r,
        input logic [7:0]             a,
        input logic [7:0]             code,
        input logic [7:0]             fstat
    );
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            sfrsd_pkg::ADDR_STACK_PTR:    d = r.stack_ptr;
            sfrsd_pkg::ADDR_DATA_PTR_WORD_LOW:     d = r.data_ptr_word[7:0];
            sfrsd_pkg::ADDR_DATA_PTR_WORD_HIGH:    d = r.data_ptr_word[15:8];
            sfrsd_pkg::ADDR_FLASH_CTRL:   d = fstat;
            sfrsd_pkg::ADDR_PROT_UNLOCK:  d = code;
            sfrsd_pkg::ADDR_WAKE_CTRL:    d = r.wake_ctrl;
            sfrsd_pkg::ADDR_SYS_OPTIONS:  d = r.system_options;
            sfrsd_pkg::ADDR_SYSCLK_SETUP: d = r.sysclk_setup;
            sfrsd_pkg::ADDR_PSW:          d = r.program_status_word;
            sfrsd_pkg::ADDR_MAIN_ARITH:   d = r.main_arith_reg;
            sfrsd_pkg::ADDR_OPERAND_AUX:  d = r.operand_aux_reg;
            sfrsd_pkg::ADDR_SPI_CLK:      d = r.serial_periph_clock_setup;
            sfrsd_pkg::ADDR_SCRATCH:      d = r.retained_scratch;
            sfrsd_pkg::ADDR_WDOG:         d = r.watchdog_tick;
            default:                      d = 8'h00;
        endcase
        return d;
    endfunction

    function automatic sfrsd_pkg::sfrsd_regs_s sfr_write(
        input sfrsd_pkg::sfrsd_regs_s r,
        input logic [7:0]             a,
        input logic [7:0]             d,
        input logic                   open
    );
        sfrsd_pkg::sfrsd_regs_s n;
        n = r;
        unique case (a)
            sfrsd_pkg::ADDR_STACK_PTR:    n.stack_ptr = d;
            sfrsd_pkg::ADDR_DATA_PTR_WORD_LOW:     n.data_ptr_word[7:0] = d;
            sfrsd_pkg::ADDR_DATA_PTR_WORD_HIGH:    n.data_ptr_word[15:8] = d;
            sfrsd_pkg::ADDR_FLASH_CTRL:   n.flash_ctrl = d;
            sfrsd_pkg::ADDR_PROT_UNLOCK:  n.protect_unlock = d;
            sfrsd_pkg::ADDR_WAKE_CTRL:
                if (open)
                    n.wake_ctrl = d;
            sfrsd_pkg::ADDR_SYS_OPTIONS:
                if (open)
                    n.system_options = d;
            sfrsd_pkg::ADDR_SYSCLK_SETUP:
                if (open)
                    n.sysclk_setup = d;
            sfrsd_pkg::ADDR_PSW:          n.program_status_word = d;
            sfrsd_pkg::ADDR_MAIN_ARITH:   n.main_arith_reg = d;
            sfrsd_pkg::ADDR_OPERAND_AUX:  n.operand_aux_reg = d;
            sfrsd_pkg::ADDR_SPI_CLK:      n.serial_periph_clock_setup = d;
            sfrsd_pkg::ADDR_SCRATCH:      n.retained_scratch = d;
            sfrsd_pkg::ADDR_WDOG:         n.watchdog_tick = d;
            default:                      n = r;
        endcase
        return n;
    endfunction

    // ---------------------------------------------------------------
    // Request decode
    // ---------------------------------------------------------------
    logic                   sfr_hit;
    logic [7:0]             byte_addr;
    logic [7:0]             device_code;
    logic [7:0]             cur_byte;
    logic [7:0]             bit_merged;
    sfrsd_pkg::sfrsd_regs_s regs_reg;

    assign sfr_hit     = req_i.valid && req_i.direct && req_i.addr[7];
    // Bit addresses select only bytes at x0h and x8h
    assign byte_addr   = req_i.bit_op ? {req_i.addr[7:3], 3'b000}
                                      : req_i.addr;
    assign device_code = variant_small_i ? CODE_SMALL : CODE_LARGE;
    assign cur_byte    = sfr_read(regs_reg, byte_addr, device_code,
                                  flash_status_i);

    always_comb
    begin
        bit_merged = cur_byte;
        bit_merged[req_i.addr[2:0]] = req_i.wbit;
    end

    // ---------------------------------------------------------------
    // Unlock sequence
    // ---------------------------------------------------------------
    sfrsd_pkg::sfrsd_unl_e unl_reg;
    sfrsd_pkg::sfrsd_unl_e unl_next;
    logic [7:0]            unl_cnt_reg;
    logic [7:0]            unl_cnt_next;
    logic                  unl_wr;
    logic                  open_reg;
    logic                  open_next;

    assign unl_wr = sfr_hit && req_i.write && !req_i.bit_op
                    && req_i.addr == sfrsd_pkg::ADDR_PROT_UNLOCK;
    assign open_next = (unl_next == sfrsd_pkg::UNL_OPEN);

    always_comb
    begin
        unl_next     = unl_reg;
        unl_cnt_next = unl_cnt_reg;
        if (!nrst_i)
        begin
            unl_next     = sfrsd_pkg::UNL_LOCKED;
            unl_cnt_next = 8'h00;
        end
        else if (unl_wr)
        begin
            unl_cnt_next = 8'h00;
            if (req_i.wdata == sfrsd_pkg::UNLOCK_KEY1)
                unl_next = sfrsd_pkg::UNL_KEY1;
            else if (req_i.wdata == sfrsd_pkg::UNLOCK_KEY2
                     && unl_reg == sfrsd_pkg::UNL_KEY1)
            begin
                unl_next     = sfrsd_pkg::UNL_OPEN;
                unl_cnt_next = sfrsd_pkg::UNLOCK_CYCLES;
            end
            else
                unl_next = sfrsd_pkg::UNL_LOCKED;
        end
        else
        begin
            unique case (unl_reg)
                sfrsd_pkg::UNL_LOCKED,
                sfrsd_pkg::UNL_KEY1:
                    unl_cnt_next = 8'h00;
                sfrsd_pkg::UNL_OPEN:
                begin
                    unl_cnt_next = unl_cnt_reg - 8'h01;
                    if (unl_cnt_reg == 8'h01)
                        unl_next = sfrsd_pkg::UNL_LOCKED;
                end
                default:
                    unl_next = sfrsd_pkg::UNL_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        unl_reg     <= unl_next;
        unl_cnt_reg <= unl_cnt_next;
        open_reg    <= open_next;
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    sfrsd_pkg::sfrsd_regs_s regs_next;
    logic                   open;
    assign open = open_reg;

    always_comb
    begin
        regs_next = regs_reg;
        if (!nrst_i)
        begin
            regs_next.stack_ptr           = sfrsd_pkg::RST_STACK_PTR;
            regs_next.data_ptr_word       = sfrsd_pkg::RST_DATA_PTR_WORD;
            regs_next.protect_unlock      = sfrsd_pkg::RST_ZERO;
            regs_next.wake_ctrl           = sfrsd_pkg::RST_ZERO;
            regs_next.sysclk_setup        = sfrsd_pkg::RST_SYSCLK;
            regs_next.program_status_word = sfrsd_pkg::RST_ZERO;
            regs_next.main_arith_reg      = sfrsd_pkg::RST_ZERO;
            regs_next.operand_aux_reg     = sfrsd_pkg::RST_ZERO;
            regs_next.serial_periph_clock_setup = sfrsd_pkg::RST_SPI_CLK;
            regs_next.flash_ctrl          = sfrsd_pkg::RST_ZERO;
            regs_next.watchdog_tick       = sfrsd_pkg::RST_ZERO;
            if (por_i)
                regs_next.retained_scratch = sfrsd_pkg::RST_ZERO;
            unique case ({variant_small_i, boot_ctx_i})
                2'b00: regs_next.system_options = sfrsd_pkg::RST_OPT_LG_APP;
                2'b01: regs_next.system_options = sfrsd_pkg::RST_OPT_LG_BOOT;
                2'b10: regs_next.system_options = sfrsd_pkg::RST_OPT_SM_APP;
                2'b11: regs_next.system_options = sfrsd_pkg::RST_OPT_SM_BOOT;
            endcase
        end
        else if (sfr_hit && req_i.write)
        begin
            if (req_i.bit_op)
                regs_next = sfr_write(regs_reg, byte_addr, bit_merged, open);
            else
                regs_next = sfr_write(regs_reg, byte_addr, req_i.wdata, open);
        end
    end

    always_ff @(posedge clock_i)
    begin
        regs_reg <= regs_next;
    end

    // ---------------------------------------------------------------
    // Read answer
    // ---------------------------------------------------------------
    logic       ack_reg;
    logic       ack_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rbit_reg;
    logic       rbit_next;

    always_comb
    begin
        ack_next   = 1'b0;
        rdata_next = 8'h00;
        rbit_next  = 1'b0;
        if (nrst_i && sfr_hit)
        begin
            ack_next = 1'b1;
            if (!req_i.write && !req_i.bit_op)
                rdata_next = cur_byte;
            if (!req_i.write && req_i.bit_op)
                rbit_next = cur_byte[req_i.addr[2:0]];
        end
    end

    always_ff @(posedge clock_i)
    begin
        ack_reg   <= ack_next;
        rdata_reg <= rdata_next;
        rbit_reg  <= rbit_next;
    end

    assign ack_o      = ack_reg;
    assign rdata_o    = rdata_reg;
    assign rbit_o     = rbit_reg;
    assign regs_o     = regs_reg;
    assign unlocked_o = open;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    logic wr_b;
    logic rd_b;
    assign wr_b = sfr_hit && req_i.write && !req_i.bit_op;
    assign rd_b = sfr_hit && !req_i.write && !req_i.bit_op;

    indirect_ignored_a:
        assert property (req_i.valid && !req_i.direct
                         |=> !ack_o && regs_o == $past(regs_o))
        else $error("indirect access reached the register space");
    bit_write_keep_a:
        assert property (sfr_hit && req_i.write && req_i.bit_op
                         && req_i.addr[7:3] == 5'b11100
                         |=> regs_o.main_arith_reg[$past(req_i.addr[2:0])]
                             == $past(req_i.wbit)
                         && ((regs_o.main_arith_reg
                             ^ $past(regs_o.main_arith_reg))
                             & ~(8'h01 << $past(req_i.addr[2:0]))) == 8'h00)
        else $error("bit write disturbed other bits");
    locked_options_a:
        assert property (wr_b && !unlocked_o
                         && req_i.addr == sfrsd_pkg::ADDR_SYS_OPTIONS
                         |=> $stable(regs_o.system_options))
        else $error("protected write taken while locked");
    unlock_opens_a:
        assert property (unl_wr && req_i.wdata == sfrsd_pkg::UNLOCK_KEY1
                         ##1 !unl_wr ##1 unl_wr
                         && req_i.wdata == sfrsd_pkg::UNLOCK_KEY2
                         |=> unlocked_o [*8])
        else $error("unlock sequence did not open");
    alias_store_a:
        assert property (wr_b && req_i.addr == sfrsd_pkg::ADDR_SPI_CLK
                         |=> regs_o.serial_periph_clock_setup
                             == $past(req_i.wdata))
        else $error("alias storage not written");
    code_read_a:
        assert property (rd_b && req_i.addr == sfrsd_pkg::ADDR_PROT_UNLOCK
                         |=> ack_o && rdata_o == $past(device_code))
        else $error("shared address did not return device code");
    flash_status_a:
        assert property (rd_b && req_i.addr == sfrsd_pkg::ADDR_FLASH_CTRL
                         |=> rdata_o == $past(flash_status_i))
        else $error("flash address did not return status");
    reset_values_a:
        assert property ($past(!nrst_i) |-> regs_o.data_ptr_word == 16'h0000
                         && regs_o.stack_ptr == sfrsd_pkg::RST_STACK_PTR
                         && regs_o.sysclk_setup == sfrsd_pkg::RST_SYSCLK
                         && regs_o.watchdog_tick == 8'h00)
        else $error("core register reset value wrong");
    scratch_keep_a:
        assert property ($past(!nrst_i && !por_i)
                         |-> $stable(regs_o.retained_scratch))
        else $error("scratch changed on a warm reset");
    unmapped_zero_a:
        assert property (rd_b && req_i.addr == 8'h84 |=> rdata_o == 8'h00)
        else $error("unassigned address read nonzero");

    unlock_seen_c:
        cover property (unl_wr ##2 unl_wr ##1 unlocked_o);
    bit_write_c:
        cover property (sfr_hit && req_i.bit_op && req_i.write);
    protected_write_c:
        cover property (wr_b && unlocked_o
                        && req_i.addr == sfrsd_pkg::ADDR_SYSCLK_SETUP);

endmodule

`default_nettype wire

//--- logic/sfrsd_pkg.sv
// Purpose: Constants and types of the special function register space
// Assumes: 8-bit direct and bit accesses from the processor core
// Notes:   Offsets are direct byte addresses in the 80h-ffh window
//
// Notes on behaviour
// - Only direct accesses to addresses 80h-ffh reach this register space.
// - Bytes at x0h and x8h take single-bit reads and writes, other bits kept.
// - Bytes at other addresses are reached by whole-byte accesses only.
// - System options, clock setup and wake control are writable only while unlocked.
// - Serial clock setup and slave preset are one storage at one address.
// - Unlock and device code share one address, flash control and status another.
// - Write-only fields store but read back the read-only value at their address, read-only fields ignore writes.
// - The unlock register is write-only and resets to zero.
// - Reads at the unlock address return a fixed code naming the variant.
// - System options reset by variant and boot context, 80h for large application.
// - The two data pointer bytes form one 16-bit pointer resetting to zero.
// - The watchdog count sits at ffh and resets to zero.
// - The retained scratch byte clears only on a power-on reset.
// - The clock setup register resets to 83h.
// - Status word, main and auxiliary arithmetic registers reset to zero.

package sfrsd_pkg;

    // ---------------------------------------------------------------
    // Addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] SFR_BASE          = 8'h80;
    localparam logic [7:0] ADDR_STACK_PTR    = 8'h81;
    localparam logic [7:0] ADDR_DATA_PTR_WORD_LOW     = 8'h82;
    localparam logic [7:0] ADDR_DATA_PTR_WORD_HIGH    = 8'h83;
    localparam logic [7:0] ADDR_FLASH_CTRL   = 8'h86;
    localparam logic [7:0] ADDR_PROT_UNLOCK  = 8'ha1;
    localparam logic [7:0] ADDR_WAKE_CTRL    = 8'ha9;
    localparam logic [7:0] ADDR_SYS_OPTIONS  = 8'hb1;
    localparam logic [7:0] ADDR_SYSCLK_SETUP = 8'hb9;
    localparam logic [7:0] ADDR_PSW          = 8'hd0;
    localparam logic [7:0] ADDR_MAIN_ARITH   = 8'he0;
    localparam logic [7:0] ADDR_OPERAND_AUX  = 8'hf0;
    localparam logic [7:0] ADDR_SPI_CLK      = 8'hfb;
    localparam logic [7:0] ADDR_SCRATCH      = 8'hfe;
    localparam logic [7:0] ADDR_WDOG         = 8'hff;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0]  RST_STACK_PTR    = 8'h07;
    localparam logic [15:0] RST_DATA_PTR_WORD         = 16'h0000;
    localparam logic [7:0]  RST_ZERO         = 8'h00;
    localparam logic [7:0]  RST_SYSCLK       = 8'h83;
    localparam logic [7:0]  RST_SPI_CLK      = 8'h20;
    localparam logic [7:0]  RST_OPT_LG_BOOT  = 8'ha0;
    localparam logic [7:0]  RST_OPT_LG_APP   = 8'h80;
    localparam logic [7:0]  RST_OPT_SM_BOOT  = 8'he0;
    localparam logic [7:0]  RST_OPT_SM_APP   = 8'hc0;

    // ---------------------------------------------------------------
    // Unlock sequence
    // ---------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY1       = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2       = 8'haa;
    localparam logic [7:0] UNLOCK_CYCLES     = 8'h40;

    typedef enum logic [1:0] {
        UNL_LOCKED,
        UNL_KEY1,
        UNL_OPEN
    } sfrsd_unl_e;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       direct;
        logic       bit_op;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wbit;
    } sfrsd_req_s;

    typedef struct packed {
        logic [7:0]  stack_ptr;
        logic [15:0] data_ptr_word;
        logic [7:0]  protect_unlock;
        logic [7:0]  system_options;
        logic [7:0]  wake_ctrl;
        logic [7:0]  sysclk_setup;
        logic [7:0]  program_status_word;
        logic [7:0]  main_arith_reg;
        logic [7:0]  operand_aux_reg;
        logic [7:0]  serial_periph_clock_setup;
        logic [7:0]  flash_ctrl;
        logic [7:0]  retained_scratch;
        logic [7:0]  watchdog_tick;
    } sfrsd_regs_s;

endpackage

//--- verification/sfrsd_core_model.sv
// Purpose: Processor core model issuing direct and bit accesses
// Assumes: Requests launched on the falling edge, one at a time
// Notes:   Released address, data and bit lines show the inverse of the last value

`timescale 1ns/1ps
`default_nettype none

module sfrsd_core_model (
    // Clock
    input  wire logic                  clock_i,
    // Request side
    output var sfrsd_pkg::sfrsd_req_s  req_o,
    // Answer side
    input  wire logic                  ack_i,
    input  wire logic [7:0]            rdata_i,
    input  wire logic                  rbit_i
);

    initial req_o = '0;

    // ---------------------------------------------------------------
    // One access, answer taken in the cycle after the taking edge
    // ---------------------------------------------------------------
    task automatic access(
        input  logic       direct,
        input  logic       bit_op,
        input  logic       write,
        input  logic [7:0] addr,
        input  logic [7:0] wdata,
        input  logic       wbit,
        output logic       ack,
        output logic [7:0] rdata,
        output logic       rbit
    );
        @(negedge clock_i);
        req_o.valid  = 1'b1;
        req_o.direct = direct;
        req_o.bit_op = bit_op;
        req_o.write  = write;
        req_o.addr   = addr;
        req_o.wdata  = wdata;
        req_o.wbit   = wbit;
        @(negedge clock_i);
        ack   = ack_i;
        rdata = rdata_i;
        rbit  = rbit_i;
        req_o.valid = 1'b0;
        req_o.addr  = ~addr;
        req_o.wdata = ~wdata;
        req_o.wbit  = ~wbit;
    endtask

endmodule

`default_nettype wire

//--- verification/tb.sv
// Purpose: Self-checking bench of the special function register space
// Assumes: Inputs change on the falling edge of clock_i
// Notes:   Device codes are arbitrary neutral values

`timescale 1ns/1ps
`default_nettype none

module tb;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic                   clock_i;
    logic                   nrst_i;
    logic                   por_i;
    logic                   variant_small_i;
    logic                   boot_ctx_i;
    logic [7:0]             flash_status_i;
    sfrsd_pkg::sfrsd_req_s  req;
    logic                   ack;
    logic [7:0]             rdata;
    logic                   rbit;
    sfrsd_pkg::sfrsd_regs_s regs;
    logic                   unl;
    logic                   got_ack;
    logic [7:0]             got_d;
    logic                   got_b;
    int                     err_count;
    int                     checks;
    int                     cyc = 0;

    // Arbitrary identification values
    localparam logic [7:0] CODE_L = 8'h3c;
    localparam logic [7:0] CODE_S = 8'h3d;
    localparam logic [7:0] RA [10] = '{8'h81, 8'h82, 8'h83, 8'hb1, 8'hb9,
        8'hd0, 8'he0, 8'hf0, 8'hfe, 8'hff};
    localparam logic [7:0] RE [10] = '{8'h07, 8'h00, 8'h00, 8'h80, 8'h83,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] OPT [4] = '{8'h80, 8'ha0, 8'hc0, 8'he0};

    sfrsd_space #(
        .CODE_LARGE      (CODE_L),
        .CODE_SMALL      (CODE_S)
    ) DUT (
        .clock_i         (clock_i),
        .nrst_i          (nrst_i),
        .por_i           (por_i),
        .variant_small_i (variant_small_i),
        .boot_ctx_i      (boot_ctx_i),
        .req_i           (req),
        .ack_o           (ack),
        .rdata_o         (rdata),
        .rbit_o          (rbit),
        .flash_status_i  (flash_status_i),
        .regs_o          (regs),
        .unlocked_o      (unl)
    );

    sfrsd_core_model u_core (
        .clock_i (clock_i),
        .req_o   (req),
        .ack_i   (ack),
        .rdata_i (rdata),
        .rbit_i  (rbit)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors=%0d checks=%0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic xfer(input logic dir, input logic bop, input logic wr,
                        input logic [7:0] a, input logic [7:0] d,
                        input logic wb);
        u_core.access(dir, bop, wr, a, d, wb, got_ack, got_d, got_b);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, 1'b0, 1'b1, a, d, 1'b0);
        check({15'h0000, got_ack}, 16'h0001);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b1, 1'b0, 1'b0, a, 8'h00, 1'b0);
        check({7'h00, got_ack, got_d}, {8'h01, exp});
    endtask

    task automatic do_reset(input logic por, input logic sm, input logic bt);
        @(negedge clock_i);
        nrst_i = 1'b0;
        por_i = por;
        variant_small_i = sm;
        boot_ctx_i = bt;
        repeat (2) @(negedge clock_i);
        nrst_i = 1'b1;
        por_i = 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_vals;
        for (int i = 0; i < 10; i++)
            rd_chk(RA[i], RE[i]);
        check({8'h00, regs.protect_unlock}, 16'h0000);
        rd_chk(8'ha1, CODE_L);
        variant_small_i = 1'b1;
        rd_chk(8'ha1, CODE_S);
        variant_small_i = 1'b0;
    endtask

    task automatic t_direct;
        wr(8'he0, 8'h11);
        xfer(1'b0, 1'b0, 1'b1, 8'he0, 8'h77, 1'b0);
        check({15'h0000, got_ack}, 16'h0000);
        xfer(1'b1, 1'b0, 1'b1, 8'h7f, 8'h77, 1'b0);
        check({15'h0000, got_ack}, 16'h0000);
        rd_chk(8'he0, 8'h11);
    endtask

    task automatic t_bits;
        wr(8'hd0, 8'h00);
        xfer(1'b1, 1'b1, 1'b1, 8'hd3, 8'h00, 1'b1);
        rd_chk(8'hd0, 8'h08);
        wr(8'hf0, 8'hff);
        xfer(1'b1, 1'b1, 1'b1, 8'hf5, 8'h00, 1'b0);
        rd_chk(8'hf0, 8'hdf);
        xfer(1'b1, 1'b1, 1'b0, 8'hf4, 8'h00, 1'b0);
        check({14'h0000, got_ack, got_b}, 16'h0003);
        xfer(1'b1, 1'b1, 1'b0, 8'hf5, 8'h00, 1'b0);
        check({14'h0000, got_ack, got_b}, 16'h0002);
        xfer(1'b1, 1'b1, 1'b1, 8'he2, 8'h00, 1'b1);
        rd_chk(8'he0, 8'h15);
        wr(8'h81, 8'h55);
        xfer(1'b1, 1'b1, 1'b1, 8'h81, 8'h00, 1'b0);
        rd_chk(8'h81, 8'h55);
    endtask

    task automatic t_protect;
        wr(8'hb1, 8'h5a);
        wr(8'hb9, 8'h5a);
        wr(8'ha9, 8'h5a);
        rd_chk(8'hb1, 8'h80);
        rd_chk(8'hb9, 8'h83);
        check({8'h00, regs.wake_ctrl}, 16'h0000);
        wr(8'ha1, 8'h55);
        wr(8'ha1, 8'h12);
        check({15'h0000, unl}, 16'h0000);
        wr(8'ha1, 8'h55);
        wr(8'ha1, 8'haa);
        check({15'h0000, unl}, 16'h0001);
        wr(8'hb1, 8'h5a);
        wr(8'hb9, 8'h5a);
        wr(8'ha9, 8'h5a);
        rd_chk(8'hb1, 8'h5a);
        rd_chk(8'hb9, 8'h5a);
        check({8'h00, regs.wake_ctrl}, 16'h005a);
        rd_chk(8'ha1, CODE_L);
        repeat (70) @(negedge clock_i);
        check({15'h0000, unl}, 16'h0000);
        wr(8'hb1, 8'h33);
        rd_chk(8'hb1, 8'h5a);
    endtask

    task automatic t_shared;
        wr(8'hfb, 8'h5c);
        check({8'h00, regs.serial_periph_clock_setup}, 16'h005c);
        rd_chk(8'hfb, 8'h5c);
        wr(8'h86, 8'h12);
        check({8'h00, regs.flash_ctrl}, 16'h0012);
        rd_chk(8'h86, 8'hc3);
        wr(8'h84, 8'hff);
        rd_chk(8'h84, 8'h00);
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        check(regs.data_ptr_word, 16'h1234);
        wr(8'hff, 8'h9a);
        rd_chk(8'hff, 8'h9a);
    endtask

    task automatic t_resets;
        wr(8'hfe, 8'ha5);
        do_reset(1'b0, 1'b0, 1'b0);
        rd_chk(8'hfe, 8'ha5);
        rd_chk(8'h81, 8'h07);
        for (int k = 0; k < 4; k++)
        begin
            do_reset(1'b1, k[1], k[0]);
            check({8'h00, regs.system_options}, {8'h00, OPT[k]});
            rd_chk(8'hfe, 8'h00);
        end
        do_reset(1'b1, 1'b0, 1'b0);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        err_count = 0;
        checks = 0;
        nrst_i = 1'b0;
        por_i = 1'b1;
        variant_small_i = 1'b0;
        boot_ctx_i = 1'b0;
        flash_status_i = 8'hc3;
        repeat (20) @(negedge clock_i);
        nrst_i = 1'b1;
        por_i = 1'b0;
        t_reset_vals();
        t_direct();
        t_bits();
        t_protect();
        t_shared();
        t_resets();
        complete_run();
    end

endmodule

`default_nettype wire
